// >>> sim/lse_exec_tb_top.sv
// self-checking testbench of the load/store execution unit
`timescale 1ns/10ps
`default_nettype none
module lse_exec_tb_top;
    import lse_pkg::*;
    logic clk, nrst, start, ptr_wr, dbg_resume, pmw_done;
    lse_op_t op;
    lse_mode_t mode;
    lse_ptr_t ptr_sel, ptr_wr_sel;
    logic [4:0] reg_idx, rf_waddr, c_ridx;
    logic [5:0] disp, io_sel, io_addr;
    logic [15:0] abs_addr, ptr_wr_val, dmem_addr, pmem_addr, pmem_wdata, pmem_rdata;
    logic [15:0] ptr_a_q, ptr_b_q, ptr_c_q, sp_q, c_addr, c_pdata;
    logic [7:0] src_data, pair_lo, pair_hi, dmem_rdata, io_rdata, dmem_wdata, io_wdata;
    logic [7:0] rf_wdata, c_wdata, c_rdata;
    logic dmem_we, dmem_re, pmem_re, pmem_we, io_we, io_re, rf_we, busy, done;
    logic sleep_req, wdt_kick, brk_req;
    logic [6:0] c_str;
    int n_mismatch = 0;
    int n_compared = 0;
    int cyc;
    lse_mode_t md[4] = '{MODE_POST_INC, MODE_PRE_DEC, MODE_DISP, MODE_PLAIN};
    logic [15:0] ea[4] = '{16'h0040, 16'h003F, 16'h007F, 16'h0040};
    logic [15:0] ep[4] = '{16'h0041, 16'h003F, 16'h0040, 16'h0040};

    lse_exec u_lse_exec (.clk, .nrst, .start, .op, .mode, .ptr_sel, .reg_idx, .disp,
        .abs_addr, .io_sel, .src_data, .pair_lo, .pair_hi, .ptr_wr, .ptr_wr_sel,
        .ptr_wr_val, .dmem_rdata, .pmem_rdata, .io_rdata, .pmw_done, .dbg_resume,
        .dmem_addr, .dmem_wdata, .dmem_we, .dmem_re, .pmem_addr, .pmem_wdata, .pmem_re,
        .pmem_we, .io_addr, .io_wdata, .io_we, .io_re, .rf_we, .rf_waddr, .rf_wdata,
        .busy, .done, .sleep_req, .wdt_kick, .brk_req, .ptr_a_q, .ptr_b_q, .ptr_c_q, .sp_q);
    lse_mem_model u_lse_mem_model (.clk, .dmem_addr, .dmem_wdata, .dmem_we, .dmem_rdata,
        .pmem_addr, .pmem_wdata, .pmem_we, .pmem_rdata, .pmw_done, .io_sel, .io_rdata);

    initial
    begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    ////////////////////////////////////////////////////////////////////////////////
    task automatic give_verdict();
        $display("compared %0d mismatched %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
        n_compared++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("[ERR] %s expected %h seen %h", name, exp, got);
        end
    endtask

    function automatic logic [15:0] ptr_of(input lse_ptr_t p);
        return p == PTR_A ? ptr_a_q : (p == PTR_B ? ptr_b_q : ptr_c_q);
    endfunction

    task automatic set_ptr(input lse_ptr_t p, input logic [15:0] v);
        ptr_wr = 1'b1;
        ptr_wr_sel = p;
        ptr_wr_val = v;
        @(posedge clk);
        #1 ptr_wr = 1'b0;
    endtask

    // present one instruction and record what the unit does until done
    task automatic run(input lse_op_t o, input lse_mode_t m, input lse_ptr_t p,
        input logic [7:0] s);
        op = o;
        mode = m;
        ptr_sel = p;
        src_data = s;
        start = 1'b1;
        cyc = 0;
        c_str = 7'h00;
        do
        begin
            @(posedge clk);
            #1 start = 1'b0;
            cyc++;
            if (dmem_re || dmem_we)
                c_addr = dmem_addr;
            if (pmem_re || pmem_we)
                c_addr = pmem_addr;
            if (io_re || io_we)
                c_addr = {10'h000, io_addr};
            if (dmem_we)
                c_wdata = dmem_wdata;
            if (io_we)
                c_wdata = io_wdata;
            if (pmem_we)
                c_pdata = pmem_wdata;
            if (rf_we)
                c_rdata = rf_wdata;
            if (rf_we)
                c_ridx = rf_waddr;
            c_str = c_str | {sleep_req, wdt_kick, io_we, io_re, pmem_re, pmem_we, brk_req};
        end while (done !== 1'b1 && cyc < 40);
        if (done !== 1'b1)
        begin
            n_mismatch++;
            $display("[ERR] done expected 1 seen %b", done);
            give_verdict();
        end
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // every addressing form back to back, pointer reloaded before each
    task automatic t_mem(input lse_op_t o, input lse_ptr_t p);
        for (int j = 0; j < 4; j++)
        begin
            set_ptr(p, 16'h0040);
            disp = 6'h3F;
            reg_idx = 5'h04 + 5'(j);
            run(o, md[j], p, 8'h90 + 8'(j));
            chk("cycles", 16'h0002, 16'(cyc));
            chk("address", ea[j], c_addr);
            chk("pointer", ep[j], ptr_of(p));
            if (o == OP_INDIRECT_READ)
            begin
                chk("read data", {8'h00, ea[j][7:0] ^ 8'h5A}, {8'h00, c_rdata});
                chk("dest", {11'h000, reg_idx}, {11'h000, c_ridx});
            end
            else
                chk("write data", {8'h00, 8'h90 + 8'(j)}, {8'h00, c_wdata});
        end
    endtask

    task automatic t_direct();
        abs_addr = 16'h0123;
        run(OP_DIRECT_WRITE, MODE_PLAIN, PTR_A, 8'h3C);
        chk("dw cycles", 16'h0002, 16'(cyc));
        chk("dw address", 16'h0123, c_addr);
        run(OP_DIRECT_READ, MODE_PLAIN, PTR_A, 8'h00);
        chk("dr data", 16'h003C, {8'h00, c_rdata});
        abs_addr = 16'h007F;
        run(OP_DIRECT_READ, MODE_PLAIN, PTR_A, 8'h00);
        chk("dr cycles", 16'h0002, 16'(cyc));
        chk("offset store", 16'h0092, {8'h00, c_rdata});
    endtask

    task automatic t_pmem();
        set_ptr(PTR_C, 16'h0011);
        reg_idx = 5'h07;
        run(OP_PMEM_READ, MODE_POST_INC, PTR_C, 8'h00);
        chk("pr cycles", 16'h0003, 16'(cyc));
        chk("pr data", 16'h00CB, {8'h00, c_rdata});
        chk("pr ptr", 16'h0012, ptr_c_q);
        chk("pr strobes", 16'h0004, {9'h000, c_str});
        run(OP_PMEM_READ_LOW, MODE_PLAIN, PTR_C, 8'h00);
        chk("prl dest", 16'h0000, {11'h000, c_ridx});
        chk("prl data", 16'h0009, {8'h00, c_rdata});
        pair_lo = 8'h12;
        pair_hi = 8'h34;
        run(OP_PMEM_WRITE, MODE_PLAIN, PTR_C, 8'h00);
        chk("pw cycles", 16'h0005, 16'(cyc));
        chk("pw strobes", 16'h0002, {9'h000, c_str});
        chk("pw data", 16'h3412, c_pdata);
        chk("pw address", 16'h0012, c_addr);
        run(OP_PMEM_READ_LOW, MODE_PLAIN, PTR_C, 8'h00);
        chk("pw readback", 16'h0012, {8'h00, c_rdata});
    endtask

    task automatic t_stack();
        run(OP_PUSH, MODE_PLAIN, PTR_A, 8'h77);
        chk("push cycles", 16'h0002, 16'(cyc));
        chk("push sp", 16'hFFFF, sp_q);
        run(OP_POP, MODE_PLAIN, PTR_A, 8'h00);
        chk("pop cycles", 16'h0002, 16'(cyc));
        chk("pop data", 16'h0077, {8'h00, c_rdata});
        chk("pop sp", SP_RST, sp_q);
    endtask

    task automatic t_ctrl();
        io_sel = 6'h15;
        run(OP_SLEEP, MODE_PLAIN, PTR_A, 8'h00);
        chk("sleep", 16'h0041, {8'h00, 1'b0, c_str} | 16'(cyc));
        run(OP_WATCHDOG_KICK, MODE_PLAIN, PTR_A, 8'h00);
        chk("kick", 16'h0021, {8'h00, 1'b0, c_str} | 16'(cyc));
        run(OP_IO_READ, MODE_PLAIN, PTR_A, 8'h00);
        chk("io read", 16'h00B0, {8'h00, c_rdata});
        chk("io read cycles", 16'h0009, {8'h00, 1'b0, c_str} | 16'(cyc));
        run(OP_IO_WRITE, MODE_PLAIN, PTR_A, 8'h5E);
        chk("io write", 16'h155E, {c_addr[7:0], c_wdata});
        chk("io write cycles", 16'h0011, {8'h00, 1'b0, c_str} | 16'(cyc));
        fork
            run(OP_BREAK, MODE_PLAIN, PTR_A, 8'h00);
            begin
                repeat (4) @(posedge clk);
                #1 dbg_resume = 1'b1;
                @(posedge clk);
                #1 dbg_resume = 1'b0;
            end
        join
        chk("break", 16'h0501, {8'(cyc), 1'b0, c_str});
        chk("break released", 16'h0000, {15'h0000, brk_req});
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial
    begin
        nrst = 1'b0;
        start = 1'b0;
        op = OP_NOP;
        mode = MODE_PLAIN;
        ptr_sel = PTR_A;
        ptr_wr_sel = PTR_A;
        reg_idx = 5'h00;
        disp = 6'h00;
        abs_addr = 16'h0000;
        io_sel = 6'h00;
        src_data = 8'h00;
        pair_lo = 8'h00;
        pair_hi = 8'h00;
        ptr_wr = 1'b0;
        ptr_wr_val = 16'h0000;
        dbg_resume = 1'b0;
        repeat (20) @(posedge clk);
        #1 nrst = 1'b1;
        @(posedge clk);
        #1;
        chk("reset pointers", PTR_RST, ptr_a_q | ptr_b_q | ptr_c_q);
        chk("reset state", {SP_RST[13:0], 2'b00}, {sp_q[13:0], busy, done});
        t_mem(OP_INDIRECT_READ, PTR_B);
        t_mem(OP_INDIRECT_READ, PTR_C);
        t_mem(OP_INDIRECT_WRITE, PTR_A);
        t_mem(OP_INDIRECT_WRITE, PTR_B);
        t_mem(OP_INDIRECT_WRITE, PTR_C);
        t_direct();
        t_pmem();
        t_stack();
        t_ctrl();
        give_verdict();
    end
endmodule
`default_nettype wire

// >>> sim/lse_mem_model.sv
// behavioural data, program and I/O memory facing the execution unit
`timescale 1ns/10ps
`default_nettype none
module lse_mem_model (
    // clock
    input wire logic clk,
    // data memory
    input wire logic [15:0] dmem_addr,
    input wire logic [7:0] dmem_wdata,
    input wire logic dmem_we,
    output logic [7:0] dmem_rdata,
    // program memory
    input wire logic [15:0] pmem_addr,
    input wire logic [15:0] pmem_wdata,
    input wire logic pmem_we,
    output logic [15:0] pmem_rdata,
    output logic pmw_done,
    // I/O space
    input wire logic [5:0] io_sel,
    output logic [7:0] io_rdata
);
    logic [7:0] dm [256];
    logic [15:0] pm [256];
    logic [1:0] cnt = 2'h0;
    initial
        for (int i = 0; i < 256; i++)
        begin
            dm[i] = 8'(i) ^ 8'h5A;
            pm[i] = {8'(i) ^ 8'hC3, 8'(i)};
        end
    // only eight address bits are decoded (dmem_addr[7:0], pmem_addr[8:1]): aliases are harmless for this bench
    assign dmem_rdata = dm[dmem_addr[7:0]];
    assign pmem_rdata = pm[pmem_addr[8:1]];
    assign io_rdata = {2'h0, io_sel} ^ 8'hA5;
    // self-programming is slow on purpose, so the unit must really wait
    assign pmw_done = pmem_we && cnt == 2'h3;
    always @(posedge clk)
    begin
        cnt <= pmem_we ? cnt + 2'h1 : 2'h0;
        if (dmem_we)
            dm[dmem_addr[7:0]] <= dmem_wdata;
        if (pmw_done)
            pm[pmem_addr[8:1]] <= pmem_wdata;
    end
endmodule
`default_nettype wire

// >>> src/lse_addr_calc.sv
// pointer address and pointer update calculation
`timescale 1ns/10ps
`default_nettype none
module lse_addr_calc (
    // pointer in
    input wire logic [15:0] ptr,
    input wire lse_pkg::lse_mode_t mode,
    input wire logic [5:0] disp,
    // results
    output logic [15:0] addr,
    output logic [15:0] ptr_new
);
    import lse_pkg::*;

    always_comb
    begin
        addr = ptr;
        ptr_new = ptr;
        unique case (mode)
            MODE_PLAIN:
            begin
                addr = ptr;
            end
            MODE_POST_INC:
            begin
                ptr_new = ptr + 16'h0001;
            end
            MODE_PRE_DEC:
            begin
                addr = ptr - 16'h0001;
                ptr_new = ptr - 16'h0001;
            end
            MODE_DISP:
            begin
                addr = ptr + {10'h000, disp};
            end
        endcase
    end
endmodule
`default_nettype wire

// >>> src/lse_exec.sv
// execution unit for data-transfer and core-control instructions
// Operation
// - post-increment read loads, bumps pointer, two cycles
// - pre-decrement read decrements first, two cycles
// - offset read uses pointer plus displacement
// - direct read from absolute address, two cycles
// - post-increment write stores, bumps pointer, two cycles
// - pre-decrement write decrements first, two cycles
// - offset write at pointer plus displacement
// - direct write to absolute address, two cycles
// - program memory read via ptr_c, three cycles
// - push stores register on stack, two cycles
// - pop loads register from stack, two cycles
// - sleep issues in one cycle
// - watchdog kick issues in one cycle
// - break only signals debug, no flags
`timescale 1ns/10ps
`default_nettype none
module lse_exec (
    // clock and reset
    input wire logic clk,
    input wire logic nrst,
    // decoded instruction
    input wire logic start,
    input wire lse_pkg::lse_op_t op,
    input wire lse_pkg::lse_mode_t mode,
    input wire lse_pkg::lse_ptr_t ptr_sel,
    input wire logic [4:0] reg_idx,
    input wire logic [5:0] disp,
    input wire logic [15:0] abs_addr,
    input wire logic [5:0] io_sel,
    // register file read side
    input wire logic [7:0] src_data,
    input wire logic [7:0] pair_lo,
    input wire logic [7:0] pair_hi,
    // pointer load from register moves
    input wire logic ptr_wr,
    input wire lse_pkg::lse_ptr_t ptr_wr_sel,
    input wire logic [15:0] ptr_wr_val,
    // memory read data and external completion
    input wire logic [7:0] dmem_rdata,
    input wire logic [15:0] pmem_rdata,
    input wire logic [7:0] io_rdata,
    input wire logic pmw_done,
    input wire logic dbg_resume,
    // data memory
    output logic [15:0] dmem_addr,
    output logic [7:0] dmem_wdata,
    output logic dmem_we,
    output logic dmem_re,
    // program memory
    output logic [15:0] pmem_addr,
    output logic [15:0] pmem_wdata,
    output logic pmem_re,
    output logic pmem_we,
    // I/O space
    output logic [5:0] io_addr,
    output logic [7:0] io_wdata,
    output logic io_we,
    output logic io_re,
    // register file write side
    output logic rf_we,
    output logic [4:0] rf_waddr,
    output logic [7:0] rf_wdata,
    // status and core control
    output logic busy,
    output logic done,
    output logic sleep_req,
    output logic wdt_kick,
    output logic brk_req,
    output logic [15:0] ptr_a_q,
    output logic [15:0] ptr_b_q,
    output logic [15:0] ptr_c_q,
    output logic [15:0] sp_q
);
    import lse_pkg::*;

    typedef struct packed {
        lse_state_t sq;
        logic [1:0] cnt;
        logic from_pmem;
        logic hi_byte;
        logic [15:0] pa, pb, pc, sp;
        logic [15:0] daddr;
        logic [7:0] dwdata;
        logic dwe, dre;
        logic [15:0] paddr, pwdata;
        logic pre, pwe;
        logic [5:0] iaddr;
        logic [7:0] iwdata;
        logic iwe, ire;
        logic rwe;
        logic [4:0] rwaddr;
        logic [7:0] rwdata;
        logic bsy, dn, slp, wdk, brk;
    } lse_s_t;

    lse_s_t s_reg;
    lse_s_t s_next;
    lse_ptr_t eff_sel;
    logic [15:0] ptr_cur;
    logic [15:0] calc_addr;
    logic [15:0] calc_ptr;
    logic acc;

    ////////////////////////////////////////////////////////////////////////
    // pointer path

    assign acc = start && (s_reg.sq == SQ_IDLE);
    // program memory forms always address through ptr_c
    assign eff_sel = (op == OP_PMEM_READ || op == OP_PMEM_READ_LOW
                      || op == OP_PMEM_WRITE) ? PTR_C : ptr_sel;
    assign ptr_cur = (eff_sel == PTR_A) ? s_reg.pa :
                     (eff_sel == PTR_B) ? s_reg.pb : s_reg.pc;

    lse_addr_calc u_calc (
        .ptr(ptr_cur),
        .mode(mode),
        .disp(disp),
        .addr(calc_addr),
        .ptr_new(calc_ptr)
    );

    ////////////////////////////////////////////////////////////////////////
    // sequencing

    always_comb
    begin
        s_next = s_reg;
        // strobes last one cycle, except pmem_we and brk_req, which are held until pmw_done or dbg_resume
        s_next.dwe = 1'b0;
        s_next.dre = 1'b0;
        s_next.pre = 1'b0;
        s_next.iwe = 1'b0;
        s_next.ire = 1'b0;
        s_next.rwe = 1'b0;
        s_next.dn = 1'b0;
        s_next.slp = 1'b0;
        s_next.wdk = 1'b0;
        // a pointer load from outside only lands while nothing is accepted
        if (ptr_wr && !acc && s_reg.sq == SQ_IDLE)
        begin
            unique case (ptr_wr_sel)
                PTR_A: s_next.pa = ptr_wr_val;
                PTR_B: s_next.pb = ptr_wr_val;
                default: s_next.pc = ptr_wr_val;
            endcase
        end
        unique case (s_reg.sq)
            SQ_IDLE:
            begin
                if (acc)
                begin
                    s_next.rwaddr = (op == OP_PMEM_READ_LOW) ? LOW_RESULT_IDX
                                                              : reg_idx;
                    s_next.from_pmem = 1'b0;
                    s_next.cnt = CYC_MEM - 2'h2;
                    s_next.sq = SQ_RUN;
                    s_next.bsy = 1'b1;
                    unique case (op)
                        OP_INDIRECT_READ, OP_INDIRECT_WRITE:
                        begin
                            // pointer changes at once; the address is already latched
                            s_next.daddr = calc_addr;
                            s_next.dre = (op == OP_INDIRECT_READ);
                            s_next.dwe = (op == OP_INDIRECT_WRITE);
                            s_next.dwdata = src_data;
                            unique case (eff_sel)
                                PTR_A: s_next.pa = calc_ptr;
                                PTR_B: s_next.pb = calc_ptr;
                                default: s_next.pc = calc_ptr;
                            endcase
                        end
                        OP_DIRECT_READ, OP_DIRECT_WRITE:
                        begin
                            s_next.daddr = abs_addr;
                            s_next.dre = (op == OP_DIRECT_READ);
                            s_next.dwe = (op == OP_DIRECT_WRITE);
                            s_next.dwdata = src_data;
                        end
                        OP_PMEM_READ, OP_PMEM_READ_LOW:
                        begin
                            s_next.paddr = s_reg.pc;
                            s_next.hi_byte = s_reg.pc[0];
                            s_next.pre = 1'b1;
                            s_next.from_pmem = 1'b1;
                            s_next.cnt = CYC_PMEM - 2'h2;
                            if (op == OP_PMEM_READ && mode == MODE_POST_INC)
                            begin
                                s_next.pc = s_reg.pc + 16'h0001;
                            end
                        end
                        OP_PMEM_WRITE:
                        begin
                            s_next.paddr = s_reg.pc;
                            s_next.pwdata = {pair_hi, pair_lo};
                            s_next.pwe = 1'b1;
                            s_next.sq = SQ_WAIT;
                        end
                        OP_PUSH:
                        begin
                            s_next.daddr = s_reg.sp;
                            s_next.dwdata = src_data;
                            s_next.dwe = 1'b1;
                            s_next.sp = s_reg.sp - 16'h0001;
                        end
                        OP_POP:
                        begin
                            s_next.daddr = s_reg.sp + 16'h0001;
                            s_next.dre = 1'b1;
                            s_next.sp = s_reg.sp + 16'h0001;
                        end
                        OP_IO_READ, OP_IO_WRITE:
                        begin
                            // the I/O space answers in the accepting cycle
                            s_next.iaddr = io_sel;
                            s_next.ire = (op == OP_IO_READ);
                            s_next.iwe = (op == OP_IO_WRITE);
                            s_next.iwdata = src_data;
                            s_next.rwe = (op == OP_IO_READ);
                            s_next.rwdata = io_rdata;
                            s_next.sq = SQ_IDLE;
                            s_next.bsy = 1'b0;
                            s_next.dn = 1'b1;
                        end
                        OP_BREAK:
                        begin
                            // held until the debugger lets the core go on
                            s_next.brk = 1'b1;
                            s_next.sq = SQ_WAIT;
                        end
                        default:
                        begin
                            // sleep, watchdog kick and no-op finish in one cycle
                            s_next.slp = (op == OP_SLEEP);
                            s_next.wdk = (op == OP_WATCHDOG_KICK);
                            s_next.sq = SQ_IDLE;
                            s_next.bsy = 1'b0;
                            s_next.dn = 1'b1;
                        end
                    endcase
                end
            end
            SQ_RUN:
            begin
                if (s_reg.cnt == 2'h0)
                begin
                    s_next.sq = SQ_IDLE;
                    s_next.bsy = 1'b0;
                    s_next.dn = 1'b1;
                    // loads write back in the last cycle; stores only finish
                    if (s_reg.from_pmem)
                    begin
                        s_next.rwe = 1'b1;
                        s_next.rwdata = s_reg.hi_byte ? pmem_rdata[15:8] : pmem_rdata[7:0];
                    end
                    else if (s_reg.dre)
                    begin
                        s_next.rwe = 1'b1;
                        s_next.rwdata = dmem_rdata;
                    end
                end
                else
                begin
                    s_next.cnt = s_reg.cnt - 2'h1;
                end
            end
            SQ_WAIT:
            begin
                if ((s_reg.pwe && pmw_done) || (s_reg.brk && dbg_resume))
                begin
                    s_next.pwe = 1'b0;
                    s_next.brk = 1'b0;
                    s_next.sq = SQ_IDLE;
                    s_next.bsy = 1'b0;
                    s_next.dn = 1'b1;
                end
            end
            default:
            begin
                s_next.sq = SQ_IDLE;
                s_next.bsy = 1'b0;
            end
        endcase
    end

    always_ff @(posedge clk)
    begin
        if (!nrst)
        begin
            s_reg <= '0;
            s_reg.pa <= PTR_RST;
            s_reg.pb <= PTR_RST;
            s_reg.pc <= PTR_RST;
            s_reg.sp <= SP_RST;
        end
        else
        begin
            s_reg <= s_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // outputs, all straight from the state register

    assign dmem_addr = s_reg.daddr;
    assign dmem_wdata = s_reg.dwdata;
    assign dmem_we = s_reg.dwe;
    assign dmem_re = s_reg.dre;
    assign pmem_addr = s_reg.paddr;
    assign pmem_wdata = s_reg.pwdata;
    assign pmem_re = s_reg.pre;
    assign pmem_we = s_reg.pwe;
    assign io_addr = s_reg.iaddr;
    assign io_wdata = s_reg.iwdata;
    assign io_we = s_reg.iwe;
    assign io_re = s_reg.ire;
    assign rf_we = s_reg.rwe;
    assign rf_waddr = s_reg.rwaddr;
    assign rf_wdata = s_reg.rwdata;
    assign busy = s_reg.bsy;
    assign done = s_reg.dn;
    assign sleep_req = s_reg.slp;
    assign wdt_kick = s_reg.wdk;
    assign brk_req = s_reg.brk;
    assign ptr_a_q = s_reg.pa;
    assign ptr_b_q = s_reg.pb;
    assign ptr_c_q = s_reg.pc;
    assign sp_q = s_reg.sp;

    ////////////////////////////////////////////////////////////////////////
    // checks

    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);

    AST_READ_TWO: assert property (acc && op == OP_INDIRECT_READ
        |-> ##1 !done ##1 done && rf_we)
        else $error("indirect read did not finish in two cycles");
    AST_PRE_DEC: assert property (acc && op == OP_INDIRECT_READ
        && mode == MODE_PRE_DEC |=> dmem_re && dmem_addr == $past(ptr_cur) - 16'h0001)
        else $error("pre-decrement address wrong");
    AST_DISP: assert property (acc && mode == MODE_DISP && eff_sel == PTR_B
        && op == OP_INDIRECT_READ |=> $stable(ptr_b_q)
        && dmem_addr == $past(ptr_cur) + {10'h000, $past(disp)})
        else $error("offset read address or pointer wrong");
    AST_DIRECT: assert property (acc && op == OP_DIRECT_READ
        |=> dmem_addr == $past(abs_addr) ##1 done && rf_we)
        else $error("direct read wrong");
    AST_POST_INC: assert property (acc && op == OP_INDIRECT_WRITE
        && mode == MODE_POST_INC && eff_sel == PTR_A |=> dmem_we && dmem_addr == $past(ptr_a_q)
        && ptr_a_q == $past(ptr_a_q) + 16'h0001)
        else $error("post-increment write wrong");
    AST_WRITE_TWO: assert property (acc && op == OP_DIRECT_WRITE
        |=> dmem_we && dmem_wdata == $past(src_data) ##1 done && !dmem_we)
        else $error("direct write timing wrong");
    AST_PMEM_THREE: assert property (acc && op == OP_PMEM_READ
        |-> ##1 pmem_re ##1 !done ##1 done && rf_we)
        else $error("program memory read not three cycles");
    AST_PUSH: assert property (acc && op == OP_PUSH
        |=> dmem_we && dmem_addr == $past(sp_q) && sp_q == $past(sp_q) - 16'h0001)
        else $error("push wrong");
    AST_POP: assert property (acc && op == OP_POP
        |=> dmem_addr == $past(sp_q) + 16'h0001 ##1 done && rf_we)
        else $error("pop wrong");
    AST_ONE_CYCLE: assert property (acc && (op == OP_SLEEP
        || op == OP_WATCHDOG_KICK || op == OP_IO_WRITE) |=> done && !busy)
        else $error("single-cycle op too slow");
    AST_LOW_TARGET: assert property (acc && op == OP_PMEM_READ_LOW
        |=> rf_waddr == LOW_RESULT_IDX)
        else $error("implicit form wrong target");
    AST_PMW: assert property (acc && op == OP_PMEM_WRITE
        |=> pmem_we && pmem_wdata == {$past(pair_hi), $past(pair_lo)} && busy)
        else $error("program memory write wrong");
    AST_BREAK: assert property (acc && op == OP_BREAK |=> brk_req && busy)
        else $error("break not raised");

    COV_LOAD: cover property (acc && op == OP_INDIRECT_READ ##2 done);
    COV_PMEM: cover property (acc && op == OP_PMEM_READ && mode == MODE_POST_INC ##3 done);
    COV_PMW: cover property (acc && op == OP_PMEM_WRITE ##[1:20] done);
    COV_BACK: cover property (done && acc);
endmodule
`default_nettype wire

// >>> src/lse_pkg.sv
// shared types and constants of the load/store execution unit
package lse_pkg;
    localparam int AW = 16;
    localparam int DW = 8;
    // cycles per instruction, counted from the accepting edge to the done cycle
    localparam logic [1:0] CYC_MEM = 2'h2;
    localparam logic [1:0] CYC_PMEM = 2'h3;
    localparam logic [1:0] CYC_ONE = 2'h1;
    // values after reset
    localparam logic [15:0] PTR_RST = 16'h0000;
    localparam logic [15:0] SP_RST = 16'h0000;
    localparam logic [4:0] LOW_RESULT_IDX = 5'h00;

    typedef enum logic [3:0] {
        OP_NOP = 4'h0,
        OP_INDIRECT_READ = 4'h1,
        OP_INDIRECT_WRITE = 4'h2,
        OP_DIRECT_READ = 4'h3,
        OP_DIRECT_WRITE = 4'h4,
        OP_PMEM_READ = 4'h5,
        OP_PMEM_READ_LOW = 4'h6,
        OP_PMEM_WRITE = 4'h7,
        OP_IO_READ = 4'h8,
        OP_IO_WRITE = 4'h9,
        OP_PUSH = 4'hA,
        OP_POP = 4'hB,
        OP_SLEEP = 4'hC,
        OP_WATCHDOG_KICK = 4'hD,
        OP_BREAK = 4'hE
    } lse_op_t;

    typedef enum logic [1:0] {
        MODE_PLAIN = 2'b00,
        MODE_POST_INC = 2'b01,
        MODE_PRE_DEC = 2'b10,
        MODE_DISP = 2'b11
    } lse_mode_t;

    typedef enum logic [1:0] {
        PTR_A = 2'b00,
        PTR_B = 2'b01,
        PTR_C = 2'b10
    } lse_ptr_t;

    typedef enum logic [1:0] {
        SQ_IDLE = 2'b00,
        SQ_RUN = 2'b01,
        SQ_WAIT = 2'b10
    } lse_state_t;
endpackage
